/* rtl/dsp_addr_regs.svh */
/*
 * Register offsets, field positions, reset values and cycle counts
 * for the operand address and repeat block.
 * Assumes inclusion by bare name from the design module only.
 */
`ifndef DSP_ADDR_REGS_SVH
`define DSP_ADDR_REGS_SVH

`define OFS_PAGE 4'h0
`define OFS_APTR 4'h1
`define OFS_STAT 4'h2
`define OFS_AUX_BIT 3

`define RST_PAGE 9'h000
`define RST_APTR 3'h0
`define RST_AUX 16'h0000
`define RST_RPT 8'h00
`define RST_WORD 16'h0000

`define F_MODE 7
`define F_UPD_HI 6
`define F_UPD_LO 4
`define F_NEWP 3
`define F_DIR_HI 6
`define F_PTR_HI 2
`define F_IMM_HI 7
`define F_HIGH_HI 11
`define F_HIGH_LO 8
`define F_XSH_HI 10

`define MULTI_EXTRA 2'h1
`define CONFLICT_EXTRA 2'h1

`endif

/* rtl/dsp_addr_pkg.sv */
/*
 * Types of the operand address and repeat block.
 * Assumes the instruction class is decoded ahead of this block.
 */
package dsp_addr_pkg;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_MULTI = 2'b01,
        ST_REPEAT = 2'b10
    } seq_state_t;

    typedef enum logic [2:0] {
        CL_SINGLE = 3'b000,
        CL_MULTI = 3'b001,
        CL_RPT_MEM = 3'b010,
        CL_RPT_IMM = 3'b011,
        CL_TWO_WORD = 3'b100,
        CL_IMM_SHORT = 3'b101
    } op_class_t;

    typedef enum logic [2:0] {
        UPD_NONE = 3'b000,
        UPD_INC = 3'b001,
        UPD_DEC = 3'b010,
        UPD_ADD0 = 3'b011,
        UPD_SUB0 = 3'b100,
        UPD_BRV_ADD = 3'b101,
        UPD_BRV_SUB = 3'b110
    } aux_update_t;
endpackage

/* rtl/dsp_addr_seq.sv */
/*
 * Operand addressing, auxiliary register unit and single-instruction
 * repeat sequencer of a 16-bit fixed-point signal processor.
 * Assumes an upstream decoder supplies the instruction class, the
 * memory operand arrives in the issue cycle, and all inputs are
 * synchronous to clock_in.
 */
`timescale 1ns/10ps
`include "dsp_addr_regs.svh"

module dsp_addr_seq #(
    parameter int AUX_COUNT = 8,
    parameter int RPT_W = 8
) (
    input wire clock_in,
    input wire reset_n_in,
    input wire issue_valid_in,
    output logic issue_ready_out,
    input wire [15:0] word_in,
    input wire [15:0] word2_in,
    input dsp_addr_pkg::op_class_t class_in,
    input wire [15:0] mem_data_in,
    input wire ext_operand_in,
    input wire ext_fetch_in,
    input wire irq_pending_in,
    output logic irq_take_out,
    output logic fetch_grant_out,
    output logic repeat_active_out,
    output logic [15:0] data_addr_out,
    output logic data_addr_valid_out,
    output logic [15:0] imm_operand_out,
    output logic [3:0] bit_select_out,
    output logic [1:0] compare_select_field_out,
    output logic [1:0] product_output_shift_out,
    output logic [2:0] aux_reg_field_out,
    output logic [2:0] store_shift_out,
    output logic [3:0] scaler_shift_out,
    output logic [3:0] io_port_number_out,
    input wire [3:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output logic [15:0] reg_rdata_out
);
    if (AUX_COUNT != 8 || RPT_W != 8) begin : g_bad_param
        $error("dsp_addr_seq serves eight aux registers and an 8-bit counter only");
    end

    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int i = 0; i < 16; i++) begin
            rev16[i] = v[15 - i];
        end
    endfunction

    function automatic logic [15:0] aux_upd(input logic [15:0] a, input logic [15:0] r0, input logic [2:0] c);
        unique case (c)
            dsp_addr_pkg::UPD_NONE: aux_upd = a;
            dsp_addr_pkg::UPD_INC: aux_upd = a + 16'h0001;
            dsp_addr_pkg::UPD_DEC: aux_upd = a - 16'h0001;
            dsp_addr_pkg::UPD_ADD0: aux_upd = a + r0;
            dsp_addr_pkg::UPD_SUB0: aux_upd = a - r0;
            dsp_addr_pkg::UPD_BRV_ADD: aux_upd = rev16(rev16(a) + rev16(r0));
            dsp_addr_pkg::UPD_BRV_SUB: aux_upd = rev16(rev16(a) - rev16(r0));
            default: aux_upd = a;
        endcase
    endfunction

    dsp_addr_pkg::seq_state_t st_q, st_d;
    dsp_addr_pkg::op_class_t cls_q, cls_d, cur_cls;
    logic [1:0] cnt_q, cnt_d, extra;
    logic [7:0] rpt_q, rpt_d;
    logic arm_q, arm_d;
    logic [15:0] held_q, held_d, held2_q, held2_d, cur_word, cur_word2;
    logic [8:0] page_q, page_d;
    logic [2:0] aptr_q, aptr_d;
    logic [15:0] aux_q [8];
    logic [15:0] aux_d [8];
    logic [15:0] sel_aux;
    logic exec, conflict, mem_acc, indirect;
    logic [15:0] addr_q, addr_d, imm_q, imm_d, rdata_q, rdata_d;
    logic addr_v_q, addr_v_d;
    logic [15:0] fld_q, fld_d;

    assign exec = (st_q == dsp_addr_pkg::ST_RUN && issue_valid_in) || st_q == dsp_addr_pkg::ST_REPEAT;
    assign cur_word = (st_q == dsp_addr_pkg::ST_REPEAT) ? held_q : word_in;
    assign cur_word2 = (st_q == dsp_addr_pkg::ST_REPEAT) ? held2_q : word2_in;
    assign cur_cls = (st_q == dsp_addr_pkg::ST_REPEAT) ? cls_q : class_in;
    assign conflict = exec && ext_operand_in && ext_fetch_in;
    assign mem_acc = exec && cur_cls != dsp_addr_pkg::CL_IMM_SHORT && cur_cls != dsp_addr_pkg::CL_TWO_WORD
                     && cur_cls != dsp_addr_pkg::CL_RPT_IMM;
    assign indirect = mem_acc && cur_word[`F_MODE];
    assign sel_aux = aux_q[aptr_q];

    assign issue_ready_out = st_q == dsp_addr_pkg::ST_RUN;
    // Operand owns the shared lines first; fetch retries next cycle
    assign fetch_grant_out = !conflict;
    assign repeat_active_out = st_q == dsp_addr_pkg::ST_REPEAT || arm_q;
    // Repeat sequence is one uninterruptible unit
    assign irq_take_out = irq_pending_in && st_q == dsp_addr_pkg::ST_RUN && !arm_q;

    // Sequencer
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        rpt_d = rpt_q;
        arm_d = arm_q;
        held_d = held_q;
        held2_d = held2_q;
        cls_d = cls_q;
        extra = 2'h0;
        unique case (st_q)
            dsp_addr_pkg::ST_RUN: begin
                if (issue_valid_in) begin
                    if (arm_q) begin
                        arm_d = 1'b0;
                        held_d = word_in;
                        held2_d = word2_in;
                        cls_d = class_in;
                        if (rpt_q != 8'h00) begin
                            st_d = dsp_addr_pkg::ST_REPEAT;
                            rpt_d = rpt_q - 8'h01;
                        end
                    end else begin
                        if (class_in == dsp_addr_pkg::CL_RPT_MEM) begin
                            rpt_d = mem_data_in[7:0];
                            arm_d = 1'b1;
                        end else if (class_in == dsp_addr_pkg::CL_RPT_IMM) begin
                            rpt_d = word_in[`F_IMM_HI:0];
                            arm_d = 1'b1;
                        end
                        if (class_in == dsp_addr_pkg::CL_MULTI) begin
                            extra = `MULTI_EXTRA;
                        end
                        if (conflict) begin
                            extra = extra + `CONFLICT_EXTRA;
                        end
                        if (extra != 2'h0) begin
                            st_d = dsp_addr_pkg::ST_MULTI;
                            cnt_d = extra;
                        end
                    end
                end
            end
            dsp_addr_pkg::ST_MULTI: begin
                cnt_d = cnt_q - 2'h1;
                if (cnt_q == 2'h1) begin
                    st_d = dsp_addr_pkg::ST_RUN;
                end
            end
            dsp_addr_pkg::ST_REPEAT: begin
                if (rpt_q == 8'h00) begin
                    st_d = dsp_addr_pkg::ST_RUN;
                end else begin
                    rpt_d = rpt_q - 8'h01;
                end
            end
            default: st_d = dsp_addr_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q <= dsp_addr_pkg::ST_RUN;
            cnt_q <= 2'h0;
            rpt_q <= `RST_RPT;
            arm_q <= 1'b0;
            held_q <= `RST_WORD;
            held2_q <= `RST_WORD;
            cls_q <= dsp_addr_pkg::CL_SINGLE;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            rpt_q <= rpt_d;
            arm_q <= arm_d;
            held_q <= held_d;
            held2_q <= held2_d;
            cls_q <= cls_d;
        end
    end

    // Address unit, fields and register port
    always_comb begin
        page_d = page_q;
        aptr_d = aptr_q;
        for (int i = 0; i < 8; i++) begin
            aux_d[i] = aux_q[i];
        end
        if (reg_wr_in) begin
            if (reg_addr_in[`OFS_AUX_BIT]) begin
                aux_d[reg_addr_in[2:0]] = reg_wdata_in;
            end else if (reg_addr_in == `OFS_PAGE) begin
                page_d = reg_wdata_in[8:0];
            end else if (reg_addr_in == `OFS_APTR) begin
                aptr_d = reg_wdata_in[2:0];
            end
        end
        // Execution overrides a colliding software write
        if (indirect) begin
            aux_d[aptr_q] = aux_upd(sel_aux, aux_q[0], cur_word[`F_UPD_HI:`F_UPD_LO]);
            if (cur_word[`F_NEWP]) begin
                aptr_d = cur_word[`F_PTR_HI:0];
            end
        end
        addr_d = addr_q;
        addr_v_d = mem_acc;
        if (mem_acc) begin
            addr_d = indirect ? sel_aux : {page_q, cur_word[`F_DIR_HI:0]};
        end
        imm_d = imm_q;
        fld_d = fld_q;
        if (exec) begin
            imm_d = (cur_cls == dsp_addr_pkg::CL_TWO_WORD) ? cur_word2 : {8'h00, cur_word[`F_IMM_HI:0]};
            fld_d = cur_word;
        end
        rdata_d = 16'h0000;
        if (reg_rd_in) begin
            if (reg_addr_in[`OFS_AUX_BIT]) begin
                rdata_d = aux_q[reg_addr_in[2:0]];
            end else if (reg_addr_in == `OFS_PAGE) begin
                rdata_d = {7'h00, page_q};
            end else if (reg_addr_in == `OFS_APTR) begin
                rdata_d = {13'h0, aptr_q};
            end else if (reg_addr_in == `OFS_STAT) begin
                rdata_d = {5'h00, st_q, arm_q, rpt_q};
            end
        end
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            page_q <= `RST_PAGE;
            aptr_q <= `RST_APTR;
            for (int i = 0; i < 8; i++) begin
                aux_q[i] <= `RST_AUX;
            end
            addr_q <= 16'h0000;
            addr_v_q <= 1'b0;
            imm_q <= 16'h0000;
            fld_q <= 16'h0000;
            rdata_q <= 16'h0000;
        end else begin
            page_q <= page_d;
            aptr_q <= aptr_d;
            for (int i = 0; i < 8; i++) begin
                aux_q[i] <= aux_d[i];
            end
            addr_q <= addr_d;
            addr_v_q <= addr_v_d;
            imm_q <= imm_d;
            fld_q <= fld_d;
            rdata_q <= rdata_d;
        end
    end

    assign data_addr_out = addr_q;
    assign data_addr_valid_out = addr_v_q;
    assign imm_operand_out = imm_q;
    assign reg_rdata_out = rdata_q;
    // Fields are decoded from every word; the consumer picks by opcode
    assign bit_select_out = fld_q[`F_HIGH_HI:`F_HIGH_LO];
    assign compare_select_field_out = fld_q[1:0];
    assign product_output_shift_out = fld_q[1:0];
    assign aux_reg_field_out = fld_q[`F_PTR_HI:0];
    assign store_shift_out = fld_q[`F_XSH_HI:`F_HIGH_LO];
    assign scaler_shift_out = fld_q[`F_HIGH_HI:`F_HIGH_LO];
    assign io_port_number_out = fld_q[`F_HIGH_HI:`F_HIGH_LO];

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    // Shared antecedent: a new instruction taken with no repeat armed
    logic fresh_issue;
    assign fresh_issue = issue_ready_out && issue_valid_in && !arm_q;

    chk_direct_addr: assert property (mem_acc && !indirect
        |=> data_addr_out == {$past(page_q), $past(cur_word[6:0])})
        else $error("direct address wrong");
    chk_page_span: assert property (mem_acc && !indirect
        |=> data_addr_out[15:7] == $past(page_q) && data_addr_valid_out)
        else $error("direct page wrong");
    chk_ind_select: assert property (indirect |=> data_addr_out == $past(sel_aux))
        else $error("indirect register wrong");
    chk_ind_incr: assert property (indirect && cur_word[6:4] == 3'b001 && !cur_word[3]
        |=> sel_aux == $past(sel_aux) + 16'h0001)
        else $error("increment wrong");
    // Software writes excluded: a pointer write would move the selection
    chk_ind_hold: assert property (indirect && cur_word[6:3] == 4'b0000 && !reg_wr_in
        |=> sel_aux == $past(sel_aux))
        else $error("unmodified register changed");
    chk_ind_decr: assert property (indirect && cur_word[6:3] == 4'b0100 && !reg_wr_in
        |=> sel_aux == $past(sel_aux) - 16'h0001)
        else $error("decrement wrong");
    chk_ind_add0: assert property (indirect && cur_word[6:3] == 4'b0110 && !reg_wr_in
        |=> sel_aux == $past(sel_aux) + $past(aux_q[0]))
        else $error("index add wrong");
    chk_ind_sub0: assert property (indirect && cur_word[6:3] == 4'b1000 && !reg_wr_in
        |=> sel_aux == $past(sel_aux) - $past(aux_q[0]))
        else $error("index subtract wrong");
    chk_ptr_load: assert property (indirect && cur_word[3] |=> aptr_q == $past(cur_word[2:0]))
        else $error("pointer load wrong");
    chk_imm_long: assert property (exec && cur_cls == dsp_addr_pkg::CL_TWO_WORD
        |=> imm_operand_out == $past(cur_word2))
        else $error("long immediate wrong");
    chk_imm_short: assert property (exec && cur_cls == dsp_addr_pkg::CL_IMM_SHORT
        |=> imm_operand_out == {8'h00, $past(cur_word[7:0])} && !data_addr_valid_out)
        else $error("short immediate wrong");
    chk_rpt_mem: assert property (fresh_issue && class_in == dsp_addr_pkg::CL_RPT_MEM
        |=> rpt_q == $past(mem_data_in[7:0]) && arm_q)
        else $error("memory repeat load wrong");
    chk_rpt_limit: assert property (issue_ready_out && issue_valid_in && arm_q && rpt_q == 8'hFF
        |=> st_q == dsp_addr_pkg::ST_REPEAT && rpt_q == 8'hFE)
        else $error("full count not repeated");
    chk_rpt_once: assert property (issue_ready_out && issue_valid_in && arm_q && rpt_q == 8'h00
        |=> issue_ready_out && !repeat_active_out)
        else $error("zero count repeated");
    chk_rpt_step: assert property (st_q == dsp_addr_pkg::ST_REPEAT && rpt_q != 8'h00
        |=> st_q == dsp_addr_pkg::ST_REPEAT && rpt_q == $past(rpt_q) - 8'h01)
        else $error("repeat step wrong");
    chk_rpt_access: assert property (st_q == dsp_addr_pkg::ST_REPEAT && mem_acc
        |=> data_addr_valid_out)
        else $error("repetition missed its access");
    chk_irq_release: assert property (st_q == dsp_addr_pkg::ST_REPEAT && rpt_q == 8'h00
        |=> irq_take_out == irq_pending_in)
        else $error("interrupt not released");
    chk_single_len: assert property (fresh_issue && class_in == dsp_addr_pkg::CL_SINGLE && !conflict
        |=> issue_ready_out)
        else $error("single-cycle instruction stalled");
    chk_bit_field: assert property (exec |=> bit_select_out == $past(cur_word[11:8]))
        else $error("bit select wrong");
    chk_cmp_field: assert property (exec |=> compare_select_field_out == $past(cur_word[1:0]))
        else $error("compare field wrong");
    chk_pshift_field: assert property (exec |=> product_output_shift_out == $past(cur_word[1:0]))
        else $error("product shift wrong");
    chk_auxreg_field: assert property (exec |=> aux_reg_field_out == $past(cur_word[2:0]))
        else $error("register field wrong");
    chk_shift_fields: assert property (exec
        |=> store_shift_out == $past(cur_word[10:8]) && scaler_shift_out == $past(cur_word[11:8]))
        else $error("shift field wrong");
    chk_port_field: assert property (exec |=> io_port_number_out == $past(cur_word[11:8]))
        else $error("port field wrong");
    chk_rpt_load: assert property (issue_ready_out && issue_valid_in && !arm_q && class_in == dsp_addr_pkg::CL_RPT_IMM
        |=> rpt_q == $past(word_in[7:0]) && arm_q)
        else $error("repeat load wrong");
    chk_rpt_count: assert property (issue_ready_out && issue_valid_in && arm_q && rpt_q == 8'h02
        |=> st_q == dsp_addr_pkg::ST_REPEAT [*2] ##1 st_q == dsp_addr_pkg::ST_RUN)
        else $error("repeat count wrong");
    chk_rpt_exit: assert property (st_q == dsp_addr_pkg::ST_REPEAT && rpt_q == 8'h00 |=> issue_ready_out)
        else $error("repeat exit wrong");
    chk_irq_hold: assert property (repeat_active_out |-> !irq_take_out)
        else $error("interrupt during repeat");
    chk_multi_len: assert property (issue_ready_out && issue_valid_in && !arm_q && class_in == dsp_addr_pkg::CL_MULTI
        && !conflict |=> !issue_ready_out ##1 issue_ready_out)
        else $error("multicycle length wrong");
    chk_conflict: assert property (issue_ready_out && conflict && !arm_q
        |-> !fetch_grant_out ##1 !issue_ready_out)
        else $error("contention not stalled");

    cov_repeat: cover property (st_q == dsp_addr_pkg::ST_REPEAT ##1 st_q == dsp_addr_pkg::ST_RUN);
    cov_multi: cover property (st_q == dsp_addr_pkg::ST_MULTI);
    cov_brv: cover property (indirect && cur_word[6:4] == 3'b101);
    cov_contention: cover property (fresh_issue && conflict);
    cov_full_repeat: cover property (st_q == dsp_addr_pkg::ST_REPEAT && rpt_q == 8'hFE);
endmodule

/* tb/tb.sv */
/*
 * Self-checking bench for the operand address and repeat sequencer.
 * Assumes the design files are compiled first; the bench drives every port.
 */
`timescale 1ns/10ps
module tb;
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic issue_valid_in = 1'b0;
    logic [15:0] word_in = 16'h0000;
    logic [15:0] word2_in = 16'h0000;
    dsp_addr_pkg::op_class_t class_in = dsp_addr_pkg::CL_SINGLE;
    logic [15:0] mem_data_in = 16'h0000;
    logic ext_operand_in = 1'b0;
    logic ext_fetch_in = 1'b0;
    logic irq_pending_in = 1'b0;
    logic [3:0] reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic issue_ready_out, irq_take_out, fetch_grant_out, repeat_active_out, data_addr_valid_out;
    logic [15:0] data_addr_out, imm_operand_out, reg_rdata_out;
    logic [3:0] bit_select_out, scaler_shift_out, io_port_number_out;
    logic [1:0] compare_select_field_out, product_output_shift_out;
    logic [2:0] aux_reg_field_out, store_shift_out;
    int fails = 0;
    int n_compared = 0;

    always #2.5 clock_in = ~clock_in;

    dsp_addr_seq uut (.clock_in(clock_in), .reset_n_in(reset_n_in), .issue_valid_in(issue_valid_in),
        .issue_ready_out(issue_ready_out), .word_in(word_in), .word2_in(word2_in), .class_in(class_in),
        .mem_data_in(mem_data_in), .ext_operand_in(ext_operand_in), .ext_fetch_in(ext_fetch_in),
        .irq_pending_in(irq_pending_in), .irq_take_out(irq_take_out), .fetch_grant_out(fetch_grant_out),
        .repeat_active_out(repeat_active_out), .data_addr_out(data_addr_out),
        .data_addr_valid_out(data_addr_valid_out), .imm_operand_out(imm_operand_out),
        .bit_select_out(bit_select_out), .compare_select_field_out(compare_select_field_out),
        .product_output_shift_out(product_output_shift_out), .aux_reg_field_out(aux_reg_field_out),
        .store_shift_out(store_shift_out), .scaler_shift_out(scaler_shift_out),
        .io_port_number_out(io_port_number_out), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out));

    task automatic finish_test();
        $display("Compared %0d, failures %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_cnt(input int got, input int exp, input string what);
        n_compared++;
        if (got != exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s count %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1;
        cmp_val(reg_rdata_out, exp, what);
    endtask

    // Waits for ready, holds the request one edge, returns with outputs settled
    task automatic issue(input dsp_addr_pkg::op_class_t c, input logic [15:0] w, input logic [15:0] w2,
                         input logic ex, output logic g);
        int k;
        k = 0;
        while (issue_ready_out !== 1'b1 && k < 400) begin
            @(posedge clock_in);
            #1;
            k++;
        end
        if (k >= 400) cmp_cnt(k, 0, "ready wait");
        @(posedge clock_in);
        issue_valid_in <= 1'b1;
        class_in <= c;
        word_in <= w;
        word2_in <= w2;
        ext_operand_in <= ex;
        ext_fetch_in <= ex;
        #1;
        g = fetch_grant_out;
        @(posedge clock_in);
        issue_valid_in <= 1'b0;
        ext_operand_in <= 1'b0;
        ext_fetch_in <= 1'b0;
        #1;
    endtask

    task automatic t_direct();
        logic g;
        reg_wr(4'h0, 16'hFFFF);
        reg_rd(4'h0, 16'h01FF, "page width");
        issue(dsp_addr_pkg::CL_SINGLE, 16'h0055, 16'h0000, 1'b0, g);
        cmp_val(data_addr_out, 16'hFFD5, "direct top page");
        cmp_val({15'h0, data_addr_valid_out}, 16'h0001, "access pulse");
        reg_wr(4'h0, 16'h00A2);
        issue(dsp_addr_pkg::CL_SINGLE, 16'hFF7F, 16'h0000, 1'b0, g);
        cmp_val(data_addr_out, 16'h517F, "direct mid page");
        reg_rd(4'h3, 16'h0000, "unmapped read");
    endtask

    task automatic t_indirect();
        logic g;
        logic [15:0] cur;
        for (int k = 0; k < 8; k++) reg_wr(4'(8 + k), 16'(16'h1000 + k));
        for (int k = 0; k < 8; k++) begin
            reg_wr(4'h1, 16'(k));
            issue(dsp_addr_pkg::CL_SINGLE, 16'h0080, 16'h0000, 1'b0, g);
            cmp_val(data_addr_out, 16'(16'h1000 + k), "pointer select");
        end
        reg_wr(4'h1, 16'h0003);
        cur = 16'h1003;
        for (int c = 0; c < 5; c++) begin
            issue(dsp_addr_pkg::CL_SINGLE, {8'h00, 1'b1, 3'(c), 4'h0}, 16'h0000, 1'b0, g);
            cmp_val(data_addr_out, cur, "indirect address");
            case (c)
                1: cur = cur + 16'h0001;
                2: cur = cur - 16'h0001;
                3: cur = cur + 16'h1000;
                4: cur = cur - 16'h1000;
                default: cur = cur;
            endcase
        end
        reg_rd(4'hB, cur, "aux after updates");
        issue(dsp_addr_pkg::CL_SINGLE, 16'h009D, 16'h0000, 1'b0, g);
        cmp_val(data_addr_out, cur, "old register used");
        reg_rd(4'hB, cur + 16'h0001, "same cycle update");
        reg_rd(4'h1, 16'h0005, "new pointer");
        issue(dsp_addr_pkg::CL_SINGLE, 16'h0080, 16'h0000, 1'b0, g);
        cmp_val(data_addr_out, 16'h1005, "next uses new");
        // Index of four walks the bit-reversed order 4, 2, 6, 1 of an eight-point transform
        reg_wr(4'h8, 16'h0004);
        reg_wr(4'h9, 16'h0004);
        reg_wr(4'h1, 16'h0001);
        cur = 16'h0004;
        for (int k = 0; k < 4; k++) begin
            issue(dsp_addr_pkg::CL_SINGLE, (k == 3) ? 16'h00E0 : 16'h00D0, 16'h0000, 1'b0, g);
            cmp_val(data_addr_out, cur, "bit-reversed step");
            cur = (k == 0) ? 16'h0002 : (k == 1) ? 16'h0006 : (k == 2) ? 16'h0001 : 16'h0006;
        end
        reg_rd(4'h9, cur, "bit-reversed result");
    endtask

    task automatic t_fields();
        logic g;
        logic [15:0] w;
        issue(dsp_addr_pkg::CL_TWO_WORD, 16'h0000, 16'hBEEF, 1'b0, g);
        cmp_val(imm_operand_out, 16'hBEEF, "second word");
        cmp_val({15'h0, data_addr_valid_out}, 16'h0000, "no memory access");
        for (int k = 0; k < 2; k++) begin
            w = (k == 0) ? 16'hA5C6 : 16'h0A39;
            issue(dsp_addr_pkg::CL_IMM_SHORT, w, 16'hFFFF, 1'b0, g);
            cmp_val(imm_operand_out, {8'h00, w[7:0]}, "short immediate");
            cmp_val({12'h0, bit_select_out}, {12'h0, w[11:8]}, "bit select");
            cmp_val({14'h0, compare_select_field_out}, {14'h0, w[1:0]}, "compare");
            cmp_val({14'h0, product_output_shift_out}, {14'h0, w[1:0]}, "product shift");
            cmp_val({13'h0, aux_reg_field_out}, {13'h0, w[2:0]}, "aux field");
            cmp_val({13'h0, store_shift_out}, {13'h0, w[10:8]}, "store shift");
            cmp_val({12'h0, scaler_shift_out}, {12'h0, w[11:8]}, "scaler shift");
            cmp_val({12'h0, io_port_number_out}, {12'h0, w[11:8]}, "io port");
        end
    endtask

    task automatic t_timing();
        logic g;
        issue(dsp_addr_pkg::CL_MULTI, 16'h0001, 16'h0000, 1'b0, g);
        cmp_val({15'h0, issue_ready_out}, 16'h0000, "multicycle stall");
        @(posedge clock_in);
        #1;
        cmp_val({15'h0, issue_ready_out}, 16'h0001, "multicycle end");
        issue(dsp_addr_pkg::CL_SINGLE, 16'h0002, 16'h0000, 1'b0, g);
        cmp_val({14'h0, g, issue_ready_out}, 16'h0003, "overlapped fetch");
        issue(dsp_addr_pkg::CL_SINGLE, 16'h0003, 16'h0000, 1'b1, g);
        cmp_val({15'h0, g}, 16'h0000, "fetch held off");
        cmp_val({15'h0, issue_ready_out}, 16'h0000, "contention cycle");
        @(posedge clock_in);
        #1;
        cmp_val({15'h0, issue_ready_out}, 16'h0001, "contention end");
    endtask

    task automatic t_repeat(input dsp_addr_pkg::op_class_t rc, input logic [7:0] cnt,
                            input dsp_addr_pkg::op_class_t body);
        logic g;
        int n;
        int b;
        @(posedge clock_in);
        irq_pending_in <= 1'b1;
        // The unused source carries the complement, so a wrong source shows
        mem_data_in <= {8'h5A, ((rc == dsp_addr_pkg::CL_RPT_MEM) ? cnt : ~cnt)};
        issue(rc, {8'h00, ((rc == dsp_addr_pkg::CL_RPT_MEM) ? ~cnt : cnt)}, 16'h0000, 1'b0, g);
        cmp_val({14'h0, repeat_active_out, irq_take_out}, 16'h0002, "armed holds irq");
        reg_rd(4'h2, {7'h00, 1'b1, cnt}, "counter loaded");
        issue(body, 16'h0011, 16'h0000, 1'b0, g);
        n = 0;
        b = 0;
        for (int i = 0; i < 300; i++) begin
            if (data_addr_valid_out === 1'b1) n++;
            if (issue_ready_out === 1'b1) break;
            if (irq_take_out !== 1'b0) cmp_cnt(i, -1, "irq during repeat");
            b++;
            @(posedge clock_in);
            #1;
        end
        cmp_cnt(n, int'(cnt) + 1, "executions");
        cmp_cnt(b, int'(cnt), "repeat cycles");
        cmp_val({14'h0, repeat_active_out, irq_take_out}, 16'h0001, "irq after repeat");
        @(posedge clock_in);
        irq_pending_in <= 1'b0;
    endtask

    initial begin
        #100000;
        fails++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge clock_in);
        reset_n_in <= 1'b1;
        #1;
        cmp_val({15'h0, issue_ready_out}, 16'h0001, "ready after reset");
        reg_rd(4'h2, 16'h0000, "status after reset");
        t_direct();
        t_indirect();
        t_fields();
        t_timing();
        // Immediate form first, then memory form at full count with a multicycle body, then memory form at zero count
        t_repeat(dsp_addr_pkg::CL_RPT_IMM, 8'h02, dsp_addr_pkg::CL_SINGLE);
        t_repeat(dsp_addr_pkg::CL_RPT_MEM, 8'hFF, dsp_addr_pkg::CL_MULTI);
        t_repeat(dsp_addr_pkg::CL_RPT_MEM, 8'h00, dsp_addr_pkg::CL_SINGLE);
        finish_test();
    end
endmodule
